// >>> pkg/piv_pkg.sv
// Constants, pin bundle and decode helpers for the parallel I/O interrupt vectoring block.
// Assumes bit n of a 12-bit word sits at index n of a [11:0] vector.
package piv_pkg;

  // ==========================================================
  // Widths
  localparam int DXW = 12;
  localparam int NS = 4;
  localparam int VEC_W = 10;
  localparam int SEL_W = 5;
  localparam int CMD_W = 4;

  // ==========================================================
  // Field positions
  localparam int FL_LSB = 0;
  localparam int WP2_BIT = 4;
  localparam int WP1_BIT = 6;
  localparam int IE_LSB = 8;
  localparam int SL_LSB = 0;
  localparam int SP_LSB = 8;
  localparam int SEL_LSB = 3;
  localparam int CMD_LSB = 8;
  localparam int SRC_HI_BIT = 10;
  localparam int SRC_LO_BIT = 11;

  // ==========================================================
  // Reset values
  localparam logic [11:0] CRA_RST = 12'h000;
  localparam logic [11:0] CRB_RST = 12'h000;
  localparam logic [11:0] VEC_RST = 12'h000;
  localparam logic [8:0] CLEAR_ALL_ADDR = 9'h007;

  // ==========================================================
  // Command codes
  typedef logic [3:0] piv_cmd_t;
  localparam piv_cmd_t CMD_READ1 = 4'h0;
  localparam piv_cmd_t CMD_READ2 = 4'h1;
  localparam piv_cmd_t CMD_SKIP1 = 4'h2;
  localparam piv_cmd_t CMD_SKIP2 = 4'h3;
  localparam piv_cmd_t CMD_SFLAG1 = 4'h4;
  localparam piv_cmd_t CMD_WCTLA = 4'h5;
  localparam piv_cmd_t CMD_RCTLA = 4'h6;
  localparam piv_cmd_t CMD_CFLAG1 = 4'h7;
  localparam piv_cmd_t CMD_WRITE1 = 4'h8;
  localparam piv_cmd_t CMD_WRITE2 = 4'h9;
  localparam piv_cmd_t CMD_SKIP3 = 4'ha;
  localparam piv_cmd_t CMD_SKIP4 = 4'hb;
  localparam piv_cmd_t CMD_WVEC = 4'hc;
  localparam piv_cmd_t CMD_WCTLB = 4'hd;
  localparam piv_cmd_t CMD_SFLAG3 = 4'he;
  localparam piv_cmd_t CMD_CFLAG3 = 4'hf;

  typedef enum {PH_IDLE, PH_READ, PH_WRITE} piv_phase_t;

  // ==========================================================
  // Pin bundle; sense[k] is sense input k+1
  typedef struct packed {
    logic addr_load;
    logic devsel_n;
    logic xtc;
    logic grant;
    logic priority_chain_input;
    logic [3:0] sense;
    logic [4:0] sel;
    logic [11:0] dx;
  } piv_pins_t;

  localparam piv_pins_t PINS_RST = '{devsel_n: 1'b1, default: '0};

  // ==========================================================
  // Bit of a per-input field for input k+1 (input 4 at the lowest bit)
  function automatic int sense_bit(input int lsb, input int k);
    sense_bit = lsb + NS - 1 - k;
  endfunction : sense_bit

  // Skip command decode: {valid, index of sense input}
  function automatic logic [2:0] skip_dec(input piv_cmd_t c);
    unique case (c)
      CMD_SKIP1: skip_dec = 3'h4;
      CMD_SKIP2: skip_dec = 3'h5;
      CMD_SKIP3: skip_dec = 3'h6;
      CMD_SKIP4: skip_dec = 3'h7;
      default: skip_dec = 3'h0;
    endcase
  endfunction : skip_dec

  // Highest priority pending input, input 1 first
  function automatic logic [1:0] top_src(input logic [3:0] p);
    top_src = 2'h3;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (p[i])
        top_src = 2'(i);
    end
  endfunction : top_src

endpackage : piv_pkg

// >>> rtl/piv_core.sv
// Control, sense and vectored interrupt logic of a parallel I/O element on a 12-bit I/O bus.
// Assumes all pins are asynchronous to clk and are resynchronised here; open-drain lines are
// resolved outside from the enables, with the pulled-up level meaning high.
`timescale 1ns/1ns
module piv_core
  import piv_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire piv_pins_t pins,
  output logic [3:0] flag,
  output logic [1:0] read_n,
  output logic [1:0] write_pulse,
  output logic [11:0] dx_o,
  output logic dx_oe,
  output logic [3:0] od_o,
  output logic c1_oe,
  output logic c2_oe,
  output logic skp_int_oe,
  output logic grant_oe,
  output logic prio_out
);

  // ==========================================================
  // Input synchronisers
  piv_pins_t meta;
  piv_pins_t s;
  logic devsel_q;
  logic [3:0] sense_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= PINS_RST;
      s <= PINS_RST;
    end
    else
    begin
      meta <= pins;
      s <= meta;
    end
  end

  // Edge history is kept on the second stage only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      devsel_q <= 1'b1;
      sense_q <= 4'h0;
    end
    else
    begin
      devsel_q <= s.devsel_n;
      sense_q <= s.sense;
    end
  end

  // ==========================================================
  // Address latch and transfer phase
  piv_cmd_t cmd;
  logic hit;
  logic clear_all;
  piv_phase_t phase;
  piv_phase_t next_phase;
  logic rd_start;
  logic wr_start;
  logic rd_end;
  logic iot_go;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd <= CMD_READ1;
      hit <= 1'b0;
      clear_all <= 1'b0;
    end
    else if (s.addr_load)
    begin
      cmd <= s.dx[CMD_LSB +: CMD_W];
      hit <= (s.dx[SEL_LSB +: SEL_W] == s.sel);
      clear_all <= (s.dx[11:3] == CLEAR_ALL_ADDR);
    end
  end

  assign rd_start = (phase == PH_IDLE) && devsel_q && !s.devsel_n && s.xtc;
  assign wr_start = (phase == PH_IDLE) && devsel_q && !s.devsel_n && !s.xtc;
  assign rd_end = (phase == PH_READ) && s.devsel_n;
  assign iot_go = (rd_start || wr_start) && hit;

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      PH_IDLE:
      begin
        if (rd_start)
          next_phase = PH_READ;
        else if (wr_start)
          next_phase = PH_WRITE;
      end
      PH_READ, PH_WRITE:
      begin
        if (s.devsel_n)
          next_phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      phase <= PH_IDLE;
    else
      phase <= next_phase;
  end

  // ==========================================================
  // Programmable registers
  logic [11:0] flag_polarity_enable_control;
  logic [11:0] sense_mode_control;
  logic [11:0] vecr;
  logic [3:0] ie;
  logic [3:0] sl;
  logic [3:0] sp;
  localparam int FL1_BIT = FL_LSB + 3;
  localparam int FL3_BIT = FL_LSB + 1;

  // Set and clear commands act at the start of either phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag_polarity_enable_control <= CRA_RST;
    else if (wr_start && hit && cmd == CMD_WCTLA)
      flag_polarity_enable_control <= s.dx;
    else if (iot_go && cmd == CMD_SFLAG1)
      flag_polarity_enable_control[FL1_BIT] <= 1'b1;
    else if (iot_go && cmd == CMD_CFLAG1)
      flag_polarity_enable_control[FL1_BIT] <= 1'b0;
    else if (iot_go && cmd == CMD_SFLAG3)
      flag_polarity_enable_control[FL3_BIT] <= 1'b1;
    else if (iot_go && cmd == CMD_CFLAG3)
      flag_polarity_enable_control[FL3_BIT] <= 1'b0;
  end

  // No read path exists for this one
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sense_mode_control <= CRB_RST;
    else if (wr_start && hit && cmd == CMD_WCTLB)
      sense_mode_control <= s.dx;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      vecr <= VEC_RST;
    else if (wr_start && hit && cmd == CMD_WVEC)
      vecr <= s.dx;
  end

  // ==========================================================
  // Sense flops, one skip and one interrupt flop per input
  logic [3:0] skip_ff;
  logic [3:0] int_ff;
  logic [2:0] skd;
  logic vec_sel;
  logic [1:0] top;
  logic pending;

  assign skd = skip_dec(cmd);
  assign top = top_src(int_ff);
  assign pending = |int_ff;

  generate
    for (genvar k = 0; k < NS; k++)
    begin : g_sense
      logic lvl;
      logic edg;
      logic skip_clr;
      logic vec_clr;

      assign ie[k] = flag_polarity_enable_control[sense_bit(IE_LSB, k)];
      assign sl[k] = sense_mode_control[sense_bit(SL_LSB, k)];
      assign sp[k] = sense_mode_control[sense_bit(SP_LSB, k)];
      assign lvl = sp[k] ? s.sense[k] : !s.sense[k];
      assign edg = sp[k] ? (s.sense[k] && !sense_q[k]) : (!s.sense[k] && sense_q[k]);
      assign skip_clr = clear_all && rd_start || rd_end && hit && skd[2] && skd[1:0] == 2'(k);
      assign vec_clr = rd_end && vec_sel && top == 2'(k);

      // Set wins over any clear in the same cycle
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          skip_ff[k] <= 1'b0;
        else if (sl[k] ? lvl : edg)
          skip_ff[k] <= 1'b1;
        else if (skip_clr)
          skip_ff[k] <= 1'b0;
      end

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          int_ff[k] <= 1'b0;
        else if (!ie[k])
          int_ff[k] <= 1'b0;
        else if (edg && !sl[k] && !s.grant)
          int_ff[k] <= 1'b1;
        else if (skip_clr || vec_clr)
          int_ff[k] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // Vector selection, frozen for the whole read phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      vec_sel <= 1'b0;
    else if (rd_start)
      vec_sel <= s.grant && s.priority_chain_input && pending;
    else if (phase == PH_IDLE)
      vec_sel <= 1'b0;
  end

  // ==========================================================
  // Outputs, all registered
  logic in_read;
  logic [11:0] vec_word;

  assign in_read = (phase == PH_READ);
  assign vec_word = {top[0], top[1], vecr[VEC_W - 1:0]};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flag <= 4'h0;
      od_o <= 4'h0;
      prio_out <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < NS; k++)
        flag[k] <= flag_polarity_enable_control[sense_bit(FL_LSB, k)];
      od_o <= 4'h0;
      prio_out <= s.priority_chain_input && !pending;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dx_o <= 12'h000;
      dx_oe <= 1'b0;
    end
    else
    begin
      dx_o <= vec_sel ? vec_word : flag_polarity_enable_control;
      dx_oe <= in_read && (vec_sel || hit && cmd == CMD_RCTLA);
    end
  end

  // Transfer type lines; a vector outranks any addressed command
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      c1_oe <= 1'b0;
      c2_oe <= 1'b0;
    end
    else
    begin
      c1_oe <= in_read && (vec_sel || hit && (cmd == CMD_RCTLA || cmd == CMD_READ1 || cmd == CMD_READ2));
      c2_oe <= in_read && vec_sel;
    end
  end

  // The skip line carries the request at address load and the skip answer in the read phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      skp_int_oe <= 1'b0;
    else
      skp_int_oe <= (s.addr_load && pending && !s.grant)
                    || (in_read && hit && skd[2] && skip_ff[skd[1:0]]);
  end

  // Any transfer while grant is high returns grant low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      grant_oe <= 1'b0;
    else
      grant_oe <= s.grant && (phase != PH_IDLE || rd_start || wr_start);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      read_n <= 2'h3;
      // Idle at the reset polarity, so no false strobe follows reset
      write_pulse <= {!CRA_RST[WP2_BIT], !CRA_RST[WP1_BIT]};
    end
    else
    begin
      read_n[0] <= !(in_read && hit && cmd == CMD_READ1);
      read_n[1] <= !(in_read && hit && cmd == CMD_READ2);
      write_pulse[0] <= (phase == PH_WRITE && hit && cmd == CMD_WRITE1) ^ !flag_polarity_enable_control[WP1_BIT];
      write_pulse[1] <= (phase == PH_WRITE && hit && cmd == CMD_WRITE2) ^ !flag_polarity_enable_control[WP2_BIT];
    end
  end

  // ==========================================================
  // Checks
  property p_flag;
    @(posedge clk) disable iff (!nrst)
    1'b1 |=> flag == $past({flag_polarity_enable_control[0], flag_polarity_enable_control[1], flag_polarity_enable_control[2], flag_polarity_enable_control[3]});
  endproperty
  a_flag: assert property (p_flag) else $error("flag pins differ from control A");

  property p_ie_hold;
    @(posedge clk) disable iff (!nrst)
    !flag_polarity_enable_control[11] |=> !int_ff[0];
  endproperty
  a_ie_hold: assert property (p_ie_hold) else $error("disabled interrupt flop set");

  property p_level_noint;
    @(posedge clk) disable iff (!nrst)
    sense_mode_control[3] && !int_ff[0] |=> !int_ff[0];
  endproperty
  a_level_noint: assert property (p_level_noint) else $error("level input raised interrupt");

  property p_wp_idle;
    @(posedge clk) disable iff (!nrst)
    phase != PH_WRITE |=> write_pulse[0] == !$past(flag_polarity_enable_control[6]);
  endproperty
  a_wp_idle: assert property (p_wp_idle) else $error("write strobe idle level wrong");

  property p_crb_cap;
    @(posedge clk) disable iff (!nrst)
    wr_start && hit && cmd == CMD_WCTLB |=> sense_mode_control == $past(s.dx);
  endproperty
  a_crb_cap: assert property (p_crb_cap) else $error("control B not captured");

  property p_vec;
    @(posedge clk) disable iff (!nrst)
    vec_sel && in_read |=> dx_oe && c1_oe && c2_oe && dx_o[9:0] == $past(vecr[9:0]);
  endproperty
  a_vec: assert property (p_vec) else $error("vector not supplied");

  property p_freeze;
    @(posedge clk) disable iff (!nrst)
    s.grant && !int_ff[1] |=> !int_ff[1];
  endproperty
  a_freeze: assert property (p_freeze) else $error("request taken during grant");

  property p_top_clear;
    @(posedge clk) disable iff (!nrst)
    rd_end && vec_sel && int_ff[0] && int_ff[2] && flag_polarity_enable_control[9] && !skd[2] && s.sense[0] == sense_q[0]
      |=> !int_ff[0] && int_ff[2];
  endproperty
  a_top_clear: assert property (p_top_clear) else $error("wrong flop cleared after vector");

  property p_novec;
    @(posedge clk) disable iff (!nrst)
    !s.priority_chain_input && phase == PH_IDLE |=> !c2_oe [*2];
  endproperty
  a_novec: assert property (p_novec) else $error("vector with priority input low");

  property p_irq;
    @(posedge clk) disable iff (!nrst)
    s.addr_load && !s.grant && pending |=> skp_int_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("request not shown on skip line");

endmodule : piv_core

// >>> test/piv_cpu_model.sv
// Behavioural processor on the far side of the I/O bus: address load, device select, data lines.
// Assumes open-drain lines are pulled up, so a line is low only while some enable is high.
`timescale 1ns/1ns
module piv_cpu_model
  import piv_pkg::*;
#(
  parameter logic [4:0] SEL = 5'h05
)
(
  input wire logic clk,
  output piv_pins_t pins,
  input wire logic [11:0] dx_o,
  input wire logic dx_oe,
  input wire logic c1_oe,
  input wire logic c2_oe,
  input wire logic skp_int_oe,
  input wire logic grant_oe
);
  logic al = 1'b0;
  logic dsel_n = 1'b1;
  logic xtc = 1'b0;
  logic drv = 1'b0;
  logic gnt_req = 1'b0;
  logic priority_chain_input = 1'b0;
  logic [3:0] sense = 4'h0;
  logic [11:0] dx_cpu = 12'h000;
  logic [11:0] dx_last = 12'h000;

  // ==========================================================
  // Wire resolution
  // Released data lines show the inverse of the last value, so a held copy never passes
  always_comb
  begin
    pins = PINS_RST;
    pins.addr_load = al;
    pins.devsel_n = dsel_n;
    pins.xtc = xtc;
    pins.grant = gnt_req & !grant_oe;
    pins.priority_chain_input = priority_chain_input;
    pins.sense = sense;
    pins.sel = SEL;
    pins.dx = dx_oe ? dx_o : (drv ? dx_cpu : ~dx_last);
  end

  always @(posedge clk)
    if (dx_oe || drv)
      dx_last <= pins.dx;

  // Processor drops its grant once a device pulls the line low
  always @(posedge clk)
    if (grant_oe)
      gnt_req <= 1'b0;

  // ==========================================================
  // Bus cycles
  task set_lines(input logic [3:0] s, input logic p, input logic g);
    @(posedge clk);
    sense <= s;
    priority_chain_input <= p;
    gnt_req <= g;
    repeat (4) @(posedge clk);
  endtask : set_lines

  // ctl = {skip line at address load, c1, c2, skip line in phase}, line levels
  task io_transfer_instruction(input logic [3:0] cmd, input logic [4:0] sel, input logic x, input logic [11:0] wd,
           output logic [11:0] rd, output logic [3:0] ctl);
    @(posedge clk);
    al <= 1'b1;
    dx_cpu <= {cmd, sel, 3'h0};
    drv <= 1'b1;
    repeat (5) @(posedge clk);
    ctl[3] = !skp_int_oe;
    al <= 1'b0;
    drv <= 1'b0;
    @(posedge clk);
    dsel_n <= 1'b0;
    xtc <= x;
    dx_cpu <= wd;
    drv <= !x;
    repeat (6) @(posedge clk);
    rd = pins.dx;
    ctl[2:0] = {!c1_oe, !c2_oe, !skp_int_oe};
    dsel_n <= 1'b1;
    drv <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : io_transfer_instruction

endmodule : piv_cpu_model

// >>> test/parallel_io_interrupt_vectoring_test.sv
// Self-checking bench for the control, sense and vectoring logic.
// Assumes the processor model drives every pin; design strap select is 5'h05.
`timescale 1ns/1ns
module parallel_io_interrupt_vectoring_test;
  import piv_pkg::*;

  localparam logic [4:0] MY = 5'h05;
  localparam logic [4:0] NO = 5'h1a;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  piv_pins_t pins;
  logic [3:0] flag;
  logic [1:0] read_n;
  logic [1:0] write_pulse;
  logic [11:0] dx_o;
  logic dx_oe;
  logic c1_oe;
  logic c2_oe;
  logic skp_int_oe;
  logic grant_oe;
  logic [3:0] od_o;
  logic prio_out;
  logic [11:0] rd;
  logic [3:0] ctl;
  int bad_count = 0;
  int n_checks = 0;

  // ==========================================================
  // Instances
  piv_core piv_core_inst (.clk(clk), .nrst(nrst), .pins(pins), .flag(flag), .read_n(read_n),
    .write_pulse(write_pulse), .dx_o(dx_o), .dx_oe(dx_oe), .od_o(od_o), .c1_oe(c1_oe), .c2_oe(c2_oe),
    .skp_int_oe(skp_int_oe), .grant_oe(grant_oe), .prio_out(prio_out));
  piv_cpu_model #(.SEL(MY)) piv_cpu_model_inst (.clk(clk), .pins(pins), .dx_o(dx_o), .dx_oe(dx_oe),
    .c1_oe(c1_oe), .c2_oe(c2_oe), .skp_int_oe(skp_int_oe), .grant_oe(grant_oe));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Compare and report
  task chk_w(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_w

  task chk_l(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: lines %b expected %b", $time, got, exp);
    end
  endtask : chk_l

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task io(input logic [3:0] c, input logic [4:0] s, input logic x, input logic [11:0] w);
    piv_cpu_model_inst.io_transfer_instruction(c, s, x, w, rd, ctl);
  endtask : io

  // ==========================================================
  // Scenarios
  task t_reset;
    chk_l(flag, 4'h0);
    chk_l({read_n, write_pulse}, 4'hf);
    $display("test reset done");
  endtask : t_reset

  task t_ctl_a;
    io(CMD_WCTLA, MY, 1'b0, 12'h04a);
    chk_l(flag, 4'b0101);
    chk_l({read_n, write_pulse}, 4'b1110);
    io(CMD_RCTLA, MY, 1'b1, 12'h000);
    chk_w(rd, 12'h04a);
    chk_l(ctl, 4'b1011);
    io(CMD_CFLAG1, MY, 1'b1, 12'h000);
    io(CMD_CFLAG3, MY, 1'b1, 12'h000);
    chk_l(flag, 4'b0000);
    io(CMD_SFLAG1, MY, 1'b1, 12'h000);
    chk_l(flag, 4'b0001);
    io(CMD_WCTLB, MY, 1'b1, 12'h000);
    chk_l(ctl, 4'b1111);
    $display("test control a done");
  endtask : t_ctl_a

  task t_vector;
    io(CMD_WVEC, MY, 1'b0, 12'h155);
    io(CMD_WCTLB, MY, 1'b0, 12'hf00);
    io(CMD_WCTLA, MY, 1'b0, 12'hf00);
    piv_cpu_model_inst.set_lines(4'b0101, 1'b1, 1'b0);
    io(CMD_RCTLA, MY, 1'b1, 12'h000);
    chk_l(ctl, 4'b0011);
    chk_l({3'h0, prio_out}, 4'h0);
    piv_cpu_model_inst.set_lines(4'b0101, 1'b1, 1'b1);
    io(CMD_READ1, NO, 1'b1, 12'h000);
    chk_w(rd, 12'h155);
    chk_l(ctl, 4'b1001);
    chk_l({3'h0, piv_cpu_model_inst.gnt_req}, 4'h0);
    piv_cpu_model_inst.set_lines(4'b0101, 1'b1, 1'b1);
    io(CMD_READ1, NO, 1'b1, 12'h000);
    chk_w(rd, 12'h555);
    // An edge seen while grant is high must not start a request
    piv_cpu_model_inst.set_lines(4'b0111, 1'b1, 1'b1);
    io(CMD_READ1, NO, 1'b1, 12'h000);
    chk_l(ctl, 4'b1111);
    chk_l({3'h0, prio_out}, 4'h1);
    chk_l(od_o, 4'h0);
    $display("test vector done");
  endtask : t_vector

  task t_priority_chain_input_low;
    piv_cpu_model_inst.set_lines(4'b0000, 1'b0, 1'b0);
    // The edge lands before grant, so a request is pending while priority is low
    piv_cpu_model_inst.set_lines(4'b0001, 1'b0, 1'b0);
    piv_cpu_model_inst.set_lines(4'b0001, 1'b0, 1'b1);
    io(CMD_READ1, NO, 1'b1, 12'h000);
    chk_l(ctl, 4'b1111);
    io(CMD_SKIP1, MY, 1'b1, 12'h000);
    chk_l(ctl, 4'b0110);
    io(CMD_RCTLA, MY, 1'b1, 12'h000);
    chk_l(ctl, 4'b1011);
    chk_w(rd, 12'hf00);
    $display("test priority low done");
  endtask : t_priority_chain_input_low

  task t_level;
    io(CMD_WCTLB, MY, 1'b0, 12'h101);
    io(CMD_WCTLA, MY, 1'b0, 12'h100);
    piv_cpu_model_inst.set_lines(4'h8, 1'b0, 1'b0);
    io(CMD_RCTLA, MY, 1'b1, 12'h000);
    chk_l(ctl, 4'b1011);
    io(CMD_SKIP4, MY, 1'b1, 12'h000);
    chk_l(ctl, 4'b1110);
    io(CMD_SKIP1, MY, 1'b1, 12'h000);
    chk_l(ctl, 4'b1110);
    $display("test level done");
  endtask : t_level

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_ctl_a;
    t_vector;
    t_priority_chain_input_low;
    t_level;
    final_report;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report;
  end

endmodule : parallel_io_interrupt_vectoring_test
